//--- verilog/amc_defines.vh
// constants for the bus master address, control and response block
`ifndef AMC_DEFINES_VH
`define AMC_DEFINES_VH

`define AMC_TRANS_IDLE    2'h0
`define AMC_TRANS_NONSEQ  2'h2
`define AMC_TRANS_SEQ     2'h3

`define AMC_SIZE_BYTE     3'h0
`define AMC_SIZE_HALF     3'h1
`define AMC_SIZE_WORD     3'h2

`define AMC_BURST_SINGLE  3'h0
`define AMC_BURST_INCR    3'h1
`define AMC_BURST_INCR8   3'h5

`define AMC_RESP_OKAY     2'h0
`define AMC_RESP_ERROR    2'h1
`define AMC_RESP_RETRY    2'h2
`define AMC_RESP_SPLIT    2'h3

`define AMC_PROT_DATA     0
`define AMC_PROT_PRIV     1
`define AMC_PROT_BUF      2
`define AMC_PROT_CACHE    3

`define AMC_LINE_BEATS    4'h8
`define AMC_ADDR_RST      32'h0000_0000

`endif

//--- verilog/amc_beat_addr.v
// address step for one beat: next byte address from size
`timescale 1ns/1ps
`default_nettype none
`include "amc_defines.vh"

module amc_beat_addr #(
  parameter AW = 32
) (
  input  wire [AW-1:0] i_addr,
  input  wire [2:0]    i_size,
  output wire [AW-1:0] o_next
);

  wire [AW-1:0] step;

  // incrementing bursts never wrap; step equals the transfer size in bytes
  assign step = (i_size == `AMC_SIZE_WORD) ? {{(AW-3){1'b0}}, 3'h4} :
                (i_size == `AMC_SIZE_HALF) ? {{(AW-3){1'b0}}, 3'h2} :
                                             {{(AW-3){1'b0}}, 3'h1};
  assign o_next = i_addr + step;

endmodule // amc_beat_addr
`default_nettype wire

//--- verilog/amc_master.v
// bus master address/control issue and slave response tracking
//
// Contract
// - master drives a 32-bit byte address; word bursts advance by four.
// - write drives direction high, read drives it low.
// - direction stays constant across every beat of a burst.
// - size encodes byte 000, halfword 001, word 010 only.
// - burst encodes single 000, incr 001, incr8 101.
// - prot bit0 high for data, bit1 high for privileged.
// - prot bit2 high if bufferable, bit3 high if cachable.
// - a started transfer is never cancelled by the master; the code drops a pending burst beat to idle on any two-cycle response.
// - ready low inserts waits; transfer finishes only when ready sampled high.
// - okay with ready high is success; okay during waits.
// - error is two cycles; master records the failure.
// - retry is two cycles; master reissues until it completes.
// - split is two cycles; master reissues when next granted.
// - transfer type idle 00, nonseq 10, seq 11; never busy.
// - all signals driven and sampled on the rising clock edge.
// - eight-beat incr burst only for line fills, else incr; the code drives single for one-beat requests.
// - during reset address and control valid, transfer type idle.
`timescale 1ns/1ps
`default_nettype none
`include "amc_defines.vh"

module amc_master #(
  parameter AW = 32
) (
  input  wire          i_clk_sys,
  input  wire          i_rst_b,
  // request side from the core
  input  wire          i_req_valid,
  input  wire [AW-1:0] i_req_addr,
  input  wire          i_req_write,
  input  wire [2:0]    i_req_size,
  input  wire [3:0]    i_req_len,
  input  wire          i_req_fill,
  input  wire          i_req_data,
  input  wire          i_req_priv,
  input  wire          i_req_buf,
  input  wire          i_req_cache,
  output wire          o_req_ready,
  output reg           o_beat_done,
  output reg           o_beat_err,
  output reg           o_burst_end,
  // bus side
  output reg  [1:0]    o_htrans,
  output reg  [AW-1:0] o_haddr,
  output reg           o_hwrite,
  output reg  [2:0]    o_hsize,
  output reg  [2:0]    o_hburst,
  output reg  [3:0]    o_hprot,
  input  wire          i_hready,
  input  wire [1:0]    i_hresp
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_BURST = 3'b010;
  localparam ST_REDO  = 3'b100;

  reg  [2:0]    state_r;
  reg  [2:0]    state_nxt;
  reg  [3:0]    left_r;
  reg  [3:0]    left_nxt;
  reg           dph_r;
  reg  [AW-1:0] dph_addr_r;
  reg           dph_first_r;
  reg  [1:0]    htrans_nxt;
  reg  [AW-1:0] haddr_nxt;
  reg           hwrite_nxt;
  reg  [2:0]    hsize_nxt;
  reg  [2:0]    hburst_nxt;
  reg  [3:0]    hprot_nxt;
  wire [AW-1:0] addr_inc;
  wire          addr_act;
  wire          resp_bad;
  wire          resp_again;

  ////////////////////////////////////////////////////////////////////////////
  amc_beat_addr #(.AW(AW)) u_step (
    .i_addr (o_haddr),
    .i_size (o_hsize),
    .o_next (addr_inc)
  );

  assign addr_act   = (o_htrans != `AMC_TRANS_IDLE);
  // first of two response cycles: ready low with a non-okay code
  assign resp_bad   = dph_r && !i_hready && (i_hresp != `AMC_RESP_OKAY);
  assign resp_again = (i_hresp == `AMC_RESP_RETRY) || (i_hresp == `AMC_RESP_SPLIT);
  // no take while an address phase ends: a retry of that beat would
  // otherwise replace the new request and reissue with its controls
  assign o_req_ready = (state_r == ST_IDLE) && i_hready && !resp_bad && !addr_act;

  ////////////////////////////////////////////////////////////////////////////
  always @* begin
    state_nxt  = state_r;
    left_nxt   = left_r;
    htrans_nxt = o_htrans;
    haddr_nxt  = o_haddr;
    hwrite_nxt = o_hwrite;
    hsize_nxt  = o_hsize;
    hburst_nxt = o_hburst;
    hprot_nxt  = o_hprot;
    case (state_r)
      ST_IDLE: begin
        if (resp_bad) begin
          htrans_nxt = `AMC_TRANS_IDLE;
          state_nxt  = resp_again ? ST_REDO : ST_IDLE;
        end else if (i_hready) begin
          if (i_req_valid && !addr_act) begin
            htrans_nxt = `AMC_TRANS_NONSEQ;
            haddr_nxt  = i_req_addr;
            hwrite_nxt = i_req_write;
            // unsupported size codes fall back to word
            hsize_nxt  = (i_req_size == `AMC_SIZE_BYTE) ? `AMC_SIZE_BYTE :
                         (i_req_size == `AMC_SIZE_HALF) ? `AMC_SIZE_HALF : `AMC_SIZE_WORD;
            if (i_req_fill) begin
              hburst_nxt = `AMC_BURST_INCR8;
              left_nxt   = `AMC_LINE_BEATS - 4'h1;
            end else if (i_req_len > 4'h1) begin
              hburst_nxt = `AMC_BURST_INCR;
              left_nxt   = i_req_len - 4'h1;
            end else begin
              hburst_nxt = `AMC_BURST_SINGLE;
              left_nxt   = 4'h0;
            end
            hprot_nxt[`AMC_PROT_DATA]  = i_req_data;
            hprot_nxt[`AMC_PROT_PRIV]  = i_req_priv;
            hprot_nxt[`AMC_PROT_BUF]   = i_req_buf;
            hprot_nxt[`AMC_PROT_CACHE] = i_req_cache;
            state_nxt = ((i_req_fill) || (i_req_len > 4'h1)) ? ST_BURST : ST_IDLE;
          end else begin
            htrans_nxt = `AMC_TRANS_IDLE;
          end
        end
      end
      ST_BURST: begin
        if (resp_bad) begin
          htrans_nxt = `AMC_TRANS_IDLE;
          // the cancelled pending beat is still owed after the reissue
          left_nxt   = addr_act ? (left_r + 4'h1) : left_r;
          state_nxt  = resp_again ? ST_REDO : ST_IDLE;
        end else if (i_hready) begin
          if (left_r != 4'h0) begin
            htrans_nxt = `AMC_TRANS_SEQ;
            haddr_nxt  = addr_inc;
            left_nxt   = left_r - 4'h1; // direction and control held
          end else begin
            htrans_nxt = `AMC_TRANS_IDLE;
            state_nxt  = ST_IDLE;
          end
        end
      end
      ST_REDO: begin
        // second response cycle: reissue the failed beat as a fresh burst start
        if (i_hready) begin
          htrans_nxt = `AMC_TRANS_NONSEQ;
          haddr_nxt  = dph_addr_r;
          // a reissued mid-burst beat becomes an undefined-length burst
          if (!dph_first_r && o_hburst != `AMC_BURST_SINGLE)
            hburst_nxt = `AMC_BURST_INCR;
          state_nxt  = (o_hburst == `AMC_BURST_SINGLE) ? ST_IDLE : ST_BURST;
        end
      end
      default: begin
        state_nxt  = ST_IDLE;
        htrans_nxt = `AMC_TRANS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r     <= ST_IDLE;
      left_r      <= 4'h0;
      dph_r       <= 1'b0;
      dph_addr_r  <= `AMC_ADDR_RST;
      dph_first_r <= 1'b0;
      o_htrans    <= `AMC_TRANS_IDLE;
      o_haddr     <= `AMC_ADDR_RST;
      o_hwrite    <= 1'b0;
      o_hsize     <= `AMC_SIZE_WORD;
      o_hburst    <= `AMC_BURST_SINGLE;
      o_hprot     <= 4'h0;
      o_beat_done <= 1'b0;
      o_beat_err  <= 1'b0;
      o_burst_end <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      left_r   <= left_nxt;
      o_htrans <= htrans_nxt;
      o_haddr  <= haddr_nxt;
      o_hwrite <= hwrite_nxt;
      o_hsize  <= hsize_nxt;
      o_hburst <= hburst_nxt;
      o_hprot  <= hprot_nxt;
      // address phase moves to data phase only on ready high
      if (i_hready) begin
        dph_r       <= addr_act;
        dph_addr_r  <= o_haddr;
        dph_first_r <= (o_htrans == `AMC_TRANS_NONSEQ);
      end
      // done only on ready high with okay; the slave alone ends the beat
      o_beat_done <= dph_r && i_hready && (i_hresp == `AMC_RESP_OKAY);
      o_beat_err  <= resp_bad && (i_hresp == `AMC_RESP_ERROR);
      o_burst_end <= dph_r && i_hready && (i_hresp == `AMC_RESP_OKAY) &&
                     (state_r != ST_BURST) && !addr_act;
    end
  end

endmodule // amc_master
`default_nettype wire

//--- verif/amc_master_properties.sv
// checker: bus master address, control and response properties
`timescale 1ns/1ps
`default_nettype none
module amc_master_props #(
  parameter AW = 32
) (
  input wire logic          i_clk_sys,
  input wire logic          i_rst_b,
  input wire logic          i_req_valid,
  input wire logic          o_req_ready,
  input wire logic          i_req_write,
  input wire logic          i_req_fill,
  input wire logic          i_req_data,
  input wire logic          i_req_priv,
  input wire logic          i_req_buf,
  input wire logic          i_req_cache,
  input wire logic          o_beat_done,
  input wire logic          o_beat_err,
  input wire logic [1:0]    o_htrans,
  input wire logic [AW-1:0] o_haddr,
  input wire logic          o_hwrite,
  input wire logic [2:0]    o_hsize,
  input wire logic [2:0]    o_hburst,
  input wire logic [3:0]    o_hprot,
  input wire logic          i_hready,
  input wire logic [1:0]    i_hresp
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // data phase tracking: address of the beat now in its data phase
  logic          dph_r;
  logic [AW-1:0] dpa_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dph_r <= 1'b0;
      dpa_r <= '0;
    end else if (i_hready) begin
      dph_r <= o_htrans != 2'h0;
      if (o_htrans != 2'h0) dpa_r <= o_haddr;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  trans_code_a: assert property (o_htrans != 2'h1) else $error("busy code driven");
  size_code_a: assert property (o_hsize <= 3'h2) else $error("bad size code");
  burst_code_a: assert property (o_hburst inside {3'h0, 3'h1, 3'h5}) else $error("bad burst code");
  hold_wait_a: assert property (!i_hready && i_hresp == 2'h0 |=>
    $stable({o_htrans, o_haddr, o_hwrite, o_hsize, o_hburst, o_hprot})) else $error("pending moved in wait");
  seq_step_a: assert property (o_htrans == 2'h3 && $past(i_hready) |->
    o_haddr == $past(o_haddr) + (32'h1 << $past(o_hsize)) && o_hwrite == $past(o_hwrite)) else $error("bad step");
  req_take_a: assert property (i_req_valid && o_req_ready |=> o_htrans == 2'h2
    && o_hwrite == $past(i_req_write) && (!$past(i_req_fill) || o_hburst == 3'h5)
    && o_hprot == $past({i_req_cache, i_req_buf, i_req_priv, i_req_data})) else $error("request not issued");
  err_idle_a: assert property (!i_hready && i_hresp != 2'h0 |=> o_htrans == 2'h0) else $error("no idle");
  err_flag_a: assert property (!i_hready && i_hresp == 2'h1 |=> o_beat_err) else $error("error lost");
  beat_done_a: assert property (dph_r && i_hready && i_hresp == 2'h0 |=> o_beat_done)
    else $error("done missing");
  reissue_a: assert property (dph_r && !i_hready && i_hresp[1] |=> o_htrans == 2'h0 ##[1:2]
    (o_htrans == 2'h2 && o_haddr == dpa_r)) else $error("no reissue");
  rst_idle_a: assert property (disable iff (1'b0) !i_rst_b |-> o_htrans == 2'h0) else $error("busy in reset");
  err_cv: cover property (o_beat_err);
  retry_cv: cover property (!i_hready && i_hresp == 2'h2);
  fill_cv: cover property (o_hburst == 3'h5 && o_htrans == 2'h3);
endmodule // amc_master_props
bind amc_master amc_master_props #(.AW(AW)) u_chk (.*);
`default_nettype wire

//--- verif/amc_slave_model.sv
// slave model: wait states and one-shot two-cycle responses
`timescale 1ns/1ps
`default_nettype none
module amc_slave_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic [1:0] i_htrans,
  input  wire logic [3:0] i_wait,
  input  wire logic [1:0] i_resp,
  output logic            o_hready,
  output logic [1:0]      o_hresp
);
  logic       act_r, ph2_r, used_r;
  logic [3:0] cnt_r;
  // bad response given once, then okay until the code is cleared
  wire bad = i_resp != 2'h0 && !used_r;
  assign o_hready = !act_r || (cnt_r == 4'h0 && (!bad || ph2_r));
  assign o_hresp = (act_r && cnt_r == 4'h0 && bad) ? i_resp : 2'h0;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {act_r, ph2_r, used_r, cnt_r} <= '0;
    end else begin
      if (i_resp == 2'h0) used_r <= 1'b0;
      if (o_hready) begin
        act_r <= i_htrans != 2'h0;
        cnt_r <= i_wait;
        ph2_r <= 1'b0;
        if (act_r && bad) used_r <= 1'b1;
      end else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
      else ph2_r <= 1'b1;
    end
  end
endmodule // amc_slave_model
`default_nettype wire

//--- verif/tb_top.sv
// testbench: bus master bursts, sizes, fills and slave responses
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((e) !== (g)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
  logic i_clk_sys = 1'b0, i_rst_b = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_fill = 1'b0;
  logic [31:0] req_addr = '0, haddr;
  logic [3:0]  req_len = '0, prot = '0, s_wait = '0, hprot;
  logic [2:0]  req_size = '0, hsize, hburst, f_burst, f_size;
  logic [1:0]  s_resp = '0, htrans, hresp;
  logic        req_ready, beat_done, beat_err, burst_end, hwrite, hready;
  logic [31:0] q[$];
  int          fail_count = 0, comparisons = 0, n_done, n_err, n_end;
  always #5 i_clk_sys = ~i_clk_sys;
  amc_master dut (.i_clk_sys, .i_rst_b, .i_req_valid(req_valid), .i_req_addr(req_addr), .i_req_write(req_write),
    .i_req_size(req_size), .i_req_len(req_len), .i_req_fill(req_fill), .i_req_data(prot[0]), .i_req_priv(prot[1]),
    .i_req_buf(prot[2]), .i_req_cache(prot[3]), .o_req_ready(req_ready), .o_beat_done(beat_done),
    .o_beat_err(beat_err), .o_burst_end(burst_end), .o_htrans(htrans), .o_haddr(haddr), .o_hwrite(hwrite),
    .o_hsize(hsize),
    .o_hburst(hburst), .o_hprot(hprot), .i_hready(hready), .i_hresp(hresp));
  amc_slave_model u_slv (.i_clk_sys, .i_rst_b, .i_htrans(htrans), .i_wait(s_wait), .i_resp(s_resp),
    .o_hready(hready), .o_hresp(hresp));
  always @(posedge i_clk_sys) begin
    if (beat_done === 1'b1) n_done++;
    if (beat_err === 1'b1) n_err++;
    if (burst_end === 1'b1) n_end++;
    if (hready === 1'b1 && htrans !== 2'h0) q.push_back(haddr);
    if (hready === 1'b1 && htrans === 2'h2) {f_burst, f_size} = {hburst, hsize};
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic run(input logic [31:0] a, input logic w, input logic [2:0] s, input logic [3:0] n,
      input logic f, input logic [1:0] r, input int exp);
    int i;
    q.delete();
    {n_done, n_err, n_end} = '0;
    @(posedge i_clk_sys);
    {s_resp, req_valid, req_addr, req_write, req_size, req_len, req_fill} <= {r, 1'b1, a, w, s, n, f};
    prot <= prot + 4'h5;
    s_wait <= s_wait ^ 4'h3;
    i = 0;
    do begin @(posedge i_clk_sys); i++; end while (req_ready !== 1'b1 && i < 50);
    `CHK("taken", 1'b1, req_ready)
    req_valid <= 1'b0;
    for (i = 0; i < 300 && (n_done + n_err < exp || htrans !== 2'h0); i++) @(posedge i_clk_sys);
    repeat (2) @(posedge i_clk_sys);
    s_resp <= 2'h0;
    `CHK("beats", exp, n_done + n_err)
    `CHK("burst end", (r == 2'h1) ? 0 : 1, n_end)
  endtask
  task automatic t_burst;
    run(32'h0000_0100, 1'b1, 3'h2, 4'h4, 1'b0, 2'h0, 4);
    `CHK("last addr", 32'h0000_010c, q[$])
    `CHK("burst", 3'h1, f_burst)
    $display("t_burst done");
  endtask
  task automatic t_sizes;
    for (int s = 0; s < 3; s++) begin
      run(32'h0000_0200, 1'b0, s[2:0], 4'h2, 1'b0, 2'h0, 2);
      `CHK("step", 32'h0000_0200 + (32'h1 << s), q[1])
      `CHK("size", s[2:0], f_size)
    end
    $display("t_sizes done");
  endtask
  task automatic t_fill_single;
    run(32'h0000_0500, 1'b0, 3'h2, 4'h3, 1'b1, 2'h0, 8);
    `CHK("fill end", 32'h0000_051c, q[$])
    `CHK("fill burst", 3'h5, f_burst)
    run(32'h0000_0600, 1'b1, 3'h1, 4'h1, 1'b0, 2'h0, 1);
    `CHK("single", 3'h0, f_burst)
    $display("t_fill_single done");
  endtask
  task automatic t_responses;
    run(32'h0000_0400, 1'b1, 3'h2, 4'h4, 1'b0, 2'h1, 1);
    `CHK("err", 1, n_err)
    `CHK("abandoned", 1, q.size())
    for (int r = 2; r < 4; r++) begin
      run(32'h0000_0300, 1'b0, 3'h2, 4'h2, 1'b0, r[1:0], 2);
      `CHK("reissue", 32'h0000_0300, q[1])
      `CHK("phases", 3, q.size())
    end
    $display("t_responses done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    i_rst_b <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    t_burst();
    t_sizes();
    t_fill_single();
    t_responses();
    tally_and_finish();
  end
  // whole run is under two hundred cycles
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
